// [shared/dsg_regs.svh]
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

// Byte offsets of the register words inside the 4 KB block window
`define DSG_RUN_GATE_OFS 12'h108
`define DSG_SLEEP_GATE_OFS 12'h118
`define DSG_DEEP_GATE_OFS 12'h128
`define DSG_RUN_CFG_OFS 12'h060
`define DSG_IRQ_STAT_OFS 12'h200
`define DSG_IRQ_MASK_OFS 12'h204

// Gate register layout: unit enables at 30, 28 and 7..0, rest read as zero
`define DSG_GATE_MASK 32'h500000FF
`define DSG_GATE_RESET 32'h00000000
`define DSG_PHY_BIT 30
`define DSG_MAC_BIT 28
`define DSG_PORT_MSB 7
`define DSG_PORT_LSB 0

// Run clock configuration: only the automatic sleep-gating enable is kept
`define DSG_ACG_BIT 27
`define DSG_CFG_MASK 32'h08000000
`define DSG_CFG_RESET 32'h00000000

// Interrupt status and mask layout
`define DSG_EV_FAULT 0
`define DSG_EV_GATE 1
`define DSG_IRQ_BITS 32'h00000003
`define DSG_IRQ_RESET 32'h00000000

// Unit numbering on the access-check port
`define DSG_UNIT_MAC 4'h8
`define DSG_UNIT_PHY 4'h9
`define DSG_UNIT_COUNT 4'hA

`endif

// [shared/dsg_pkg.sv]
package dsg_pkg;

`include "dsg_regs.svh"

    // Power state as seen by the gating selector
    typedef enum logic [1:0] {
        DSG_RUN = 2'b00,
        DSG_SLEEP = 2'b01,
        DSG_DEEP = 2'b10
    } dsg_pwr_e;

    // Compact enable vector: {phy, mac, port_h .. port_a}
    typedef logic [9:0] dsg_gate_t;

    // Access to a gated unit, and the verdict on it
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] unit;
    } dsg_req_s;

    typedef struct packed {
        logic done;
        logic fault;
    } dsg_rsp_s;

    // Pick the unit enables out of a full gate register word
    function automatic dsg_gate_t dsg_compact(input logic [31:0] r);
        return {r[`DSG_PHY_BIT], r[`DSG_MAC_BIT], r[`DSG_PORT_MSB:`DSG_PORT_LSB]};
    endfunction

    // Unit numbers past the last unit count as unclocked
    function automatic logic dsg_unit_on(input dsg_gate_t g, input logic [3:0] u);
        logic on;
        on = 1'b0;
        for (int i = 0; i < 10; i++) begin
            if (u == i[3:0]) begin
                on = g[i];
            end
        end
        return on;
    endfunction

endpackage

// [verilog/dsg_fault.sv]
`timescale 1ns/100ps
`include "dsg_regs.svh"

// Judges each unit access against the clock enables now applied
module dsg_fault
    import dsg_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire dsg_gate_t gate_i,
    input wire dsg_req_s req_i,
    output dsg_rsp_s rsp_o,
    output logic fault_pulse_o
);

    dsg_rsp_s rsp_q;
    logic fault_q;
    wire logic unit_on;
    wire logic fault_d;

    // Verdict uses the applied enables, so a unit being gated off faults at once
    assign unit_on = dsg_unit_on(gate_i, req_i.unit);
    assign fault_d = req_i.valid & ~unit_on; // see [RULE_02]

    // One verdict per request, one cycle after it
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rsp_q <= '0;
            fault_q <= 1'b0;
        end else begin
            rsp_q.done <= req_i.valid;
            rsp_q.fault <= fault_d;
            fault_q <= fault_d;
        end
    end

    assign rsp_o = rsp_q;
    assign fault_pulse_o = fault_q;

    property p_gated_faults;
        @(posedge clock_i) disable iff (sys_rst_i)
        (req_i.valid && !dsg_unit_on(gate_i, req_i.unit)) |=> (rsp_o.done && rsp_o.fault);
    endproperty
    a_gated_faults: assert property (p_gated_faults) // see [RULE_02]
        else $error("access to unclocked unit did not fault");

    property p_clocked_passes;
        @(posedge clock_i) disable iff (sys_rst_i)
        (req_i.valid && dsg_unit_on(gate_i, req_i.unit)) |=> (rsp_o.done && !rsp_o.fault);
    endproperty
    a_clocked_passes: assert property (p_clocked_passes) // see [RULE_01]
        else $error("access to clocked unit faulted");

endmodule

// [verilog/dsg_top.sv]
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "dsg_regs.svh"

// How it works
// [RULE_01] A unit whose applied enable bit is one gets its clock, and a zero keeps it unclocked.
// [RULE_02] An access aimed at a unit whose clock is off is answered with a bus fault.
// [RULE_03] Reset clears every gating bit so all units start unclocked.
// [RULE_04] The run, sleep and deep-sleep gate registers apply in run, sleep and deep-sleep.
// [RULE_05] The sleep and deep-sleep registers apply only while automatic sleep gating is on.
// [RULE_06] Bit 30 is read-write and gates the Ethernet PHY clock in deep-sleep.
// [RULE_07] Bit 28 is read-write and gates the Ethernet MAC clock in deep-sleep.
// [RULE_08] Bits 7 to 0 are read-write and gate ports H down to A in deep-sleep.
// [RULE_09] Software ignores reserved bits and writes back what it read of them.
// [RULE_10] Software must enable each unit it needs, since none is clocked after reset.
// [RULE_11] Reserved bits read as zero and ignore writes.
// [RULE_12] With automatic sleep gating off the run register governs in every power state.
module dsg_top
    import dsg_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sleep_i,
    input wire logic deep_sleep_i,
    input wire dsg_req_s unit_req_i,
    output dsg_rsp_s unit_rsp_o,
    output dsg_gate_t unit_clk_en_o,
    output logic irq_o
);

    // Register state
    logic [31:0] run_gate_q;
    logic [31:0] run_gate_d;
    logic [31:0] sleep_gate_q;
    logic [31:0] sleep_gate_d;
    logic [31:0] deep_gate_q;
    logic [31:0] deep_gate_d;
    logic [31:0] run_cfg_q;
    logic [31:0] run_cfg_d;
    logic [31:0] irq_stat_q;
    logic [31:0] irq_stat_d;
    logic [31:0] irq_mask_q;
    logic [31:0] irq_mask_d;
    dsg_gate_t clk_en_q;
    dsg_gate_t clk_en_d;
    logic irq_q;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    wire logic fault_pulse;

    // APB phase decode; the access phase always takes one wait state
    wire logic apb_access;
    wire logic apb_fire;
    wire logic wr_fire;
    wire logic aligned;
    wire logic hit_run;
    wire logic hit_sleep;
    wire logic hit_deep;
    wire logic hit_cfg;
    wire logic hit_stat;
    wire logic hit_mask;
    wire logic hit_any;
    assign apb_access = psel_i & penable_i;
    assign apb_fire = apb_access & pready_q;
    assign aligned = (paddr_i[1:0] == 2'b00);
    assign hit_run = aligned & (paddr_i == `DSG_RUN_GATE_OFS);
    assign hit_sleep = aligned & (paddr_i == `DSG_SLEEP_GATE_OFS);
    assign hit_deep = aligned & (paddr_i == `DSG_DEEP_GATE_OFS);
    assign hit_cfg = aligned & (paddr_i == `DSG_RUN_CFG_OFS);
    assign hit_stat = aligned & (paddr_i == `DSG_IRQ_STAT_OFS);
    assign hit_mask = aligned & (paddr_i == `DSG_IRQ_MASK_OFS);
    assign hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask;
    assign wr_fire = apb_fire & pwrite_i & hit_any;

    // Ready rises after one access cycle; unmapped or misaligned addresses error out
    assign pready_d = apb_access & ~pready_q;
    assign pslverr_d = apb_access & ~pready_q & ~hit_any;

    // Read mux; reserved bits come back zero because they are never stored
    assign prdata_d = (~apb_access | pwrite_i | pready_q) ? 32'h00000000 :
                      hit_run ? run_gate_q :
                      hit_sleep ? sleep_gate_q :
                      hit_deep ? deep_gate_q : // see [RULE_06] [RULE_07] [RULE_08]
                      hit_cfg ? run_cfg_q :
                      hit_stat ? irq_stat_q :
                      hit_mask ? irq_mask_q : 32'h00000000;

    // Writes keep only implemented bits, so reserved positions stay zero
    assign run_gate_d = (wr_fire & hit_run) ?
                        (pwdata_i & `DSG_GATE_MASK) : run_gate_q; // see [RULE_11]
    assign sleep_gate_d = (wr_fire & hit_sleep) ?
                          (pwdata_i & `DSG_GATE_MASK) : sleep_gate_q; // see [RULE_11]
    assign deep_gate_d = (wr_fire & hit_deep) ?
                         (pwdata_i & `DSG_GATE_MASK) : deep_gate_q; // see [RULE_06] [RULE_07]
    assign run_cfg_d = (wr_fire & hit_cfg) ? (pwdata_i & `DSG_CFG_MASK) : run_cfg_q;
    assign irq_mask_d = (wr_fire & hit_mask) ? (pwdata_i & `DSG_IRQ_BITS) : irq_mask_q;

    // Power state; deep-sleep outranks sleep if both are raised
    dsg_pwr_e pwr_state;
    wire logic acg_on;
    wire logic [31:0] sel_gate;
    assign pwr_state = deep_sleep_i ? DSG_DEEP : (sleep_i ? DSG_SLEEP : DSG_RUN);
    assign acg_on = run_cfg_q[`DSG_ACG_BIT];

    // Without automatic gating the run register rules in every state
    assign sel_gate = (!acg_on || pwr_state == DSG_RUN) ? run_gate_q : // see [RULE_05] [RULE_12]
                      (pwr_state == DSG_SLEEP) ? sleep_gate_q :
                      deep_gate_q; // see [RULE_04]
    assign clk_en_d = dsg_compact(sel_gate); // see [RULE_01]

    // Events: access faults and any change of the applied enables
    wire logic [31:0] irq_set;
    wire logic [31:0] irq_clr;
    assign irq_set = ({31'h00000000, fault_pulse} << `DSG_EV_FAULT) |
                     ({31'h00000000, (clk_en_d != clk_en_q)} << `DSG_EV_GATE);
    assign irq_clr = (wr_fire & hit_stat) ? (pwdata_i & `DSG_IRQ_BITS) : 32'h00000000;

    // A set in the same cycle as its clear wins, so no event is lost
    assign irq_stat_d = ((irq_stat_q & ~irq_clr) | irq_set) & `DSG_IRQ_BITS;

    // Register bank; reset leaves every unit unclocked
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            run_gate_q <= `DSG_GATE_RESET; // see [RULE_03]
            sleep_gate_q <= `DSG_GATE_RESET; // see [RULE_03]
            deep_gate_q <= `DSG_GATE_RESET; // see [RULE_03]
            run_cfg_q <= `DSG_CFG_RESET;
            irq_mask_q <= `DSG_IRQ_RESET;
            irq_stat_q <= `DSG_IRQ_RESET;
        end else begin
            run_gate_q <= run_gate_d;
            sleep_gate_q <= sleep_gate_d;
            deep_gate_q <= deep_gate_d;
            run_cfg_q <= run_cfg_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
        end
    end

    // Applied enables and the interrupt line, all straight from flops
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            clk_en_q <= '0; // see [RULE_03]
            irq_q <= 1'b0;
        end else begin
            clk_en_q <= clk_en_d; // see [RULE_01]
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end

    // APB answer flops
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Access checker works on the enables now driven to the units
    dsg_fault u_fault (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .gate_i(clk_en_q),
        .req_i(unit_req_i),
        .rsp_o(unit_rsp_o),
        .fault_pulse_o(fault_pulse)
    );

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign unit_clk_en_o = clk_en_q;
    assign irq_o = irq_q;

    // Checks on the gating behaviour
    property p_en_follows_sel;
        @(posedge clock_i) disable iff (sys_rst_i)
        ##1 (unit_clk_en_o == dsg_compact($past(sel_gate)));
    endproperty
    a_en_follows_sel: assert property (p_en_follows_sel) // see [RULE_01]
        else $error("unit enables do not follow the selected register");

    property p_reset_clears;
        @(posedge clock_i)
        sys_rst_i |=> (unit_clk_en_o == '0 && deep_gate_q == `DSG_GATE_RESET
                       && run_gate_q == `DSG_GATE_RESET && sleep_gate_q == `DSG_GATE_RESET);
    endproperty
    a_reset_clears: assert property (p_reset_clears) // see [RULE_03]
        else $error("reset left a unit enabled");

    property p_run_uses_run;
        @(posedge clock_i) disable iff (sys_rst_i)
        (!sleep_i && !deep_sleep_i) |=> (unit_clk_en_o == dsg_compact($past(run_gate_q)));
    endproperty
    a_run_uses_run: assert property (p_run_uses_run) // see [RULE_04]
        else $error("run state not gated by run register");

    property p_deep_uses_deep;
        @(posedge clock_i) disable iff (sys_rst_i)
        (deep_sleep_i && run_cfg_q[`DSG_ACG_BIT])
            |=> (unit_clk_en_o == dsg_compact($past(deep_gate_q)));
    endproperty
    a_deep_uses_deep: assert property (p_deep_uses_deep) // see [RULE_04]
        else $error("deep-sleep not gated by deep-sleep register");

    property p_sleep_uses_sleep;
        @(posedge clock_i) disable iff (sys_rst_i)
        (sleep_i && !deep_sleep_i && run_cfg_q[`DSG_ACG_BIT])
            |=> (unit_clk_en_o == dsg_compact($past(sleep_gate_q)));
    endproperty
    a_sleep_uses_sleep: assert property (p_sleep_uses_sleep) // see [RULE_05]
        else $error("sleep not gated by sleep register");

    property p_no_acg_run;
        @(posedge clock_i) disable iff (sys_rst_i)
        !run_cfg_q[`DSG_ACG_BIT] |=> (unit_clk_en_o == dsg_compact($past(run_gate_q)));
    endproperty
    a_no_acg_run: assert property (p_no_acg_run) // see [RULE_12]
        else $error("run register not governing with auto gating off");

    property p_phy_bit;
        @(posedge clock_i) disable iff (sys_rst_i)
        (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `DSG_DEEP_GATE_OFS)
            |=> (deep_gate_q[`DSG_PHY_BIT] == $past(pwdata_i[`DSG_PHY_BIT]));
    endproperty
    a_phy_bit: assert property (p_phy_bit) // see [RULE_06]
        else $error("phy gate bit not written");

    property p_mac_bit;
        @(posedge clock_i) disable iff (sys_rst_i)
        (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `DSG_DEEP_GATE_OFS)
            |=> (deep_gate_q[`DSG_MAC_BIT] == $past(pwdata_i[`DSG_MAC_BIT]));
    endproperty
    a_mac_bit: assert property (p_mac_bit) // see [RULE_07]
        else $error("mac gate bit not written");

    property p_port_bits;
        @(posedge clock_i) disable iff (sys_rst_i)
        (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `DSG_DEEP_GATE_OFS)
            |=> (deep_gate_q[7:0] == $past(pwdata_i[7:0]));
    endproperty
    a_port_bits: assert property (p_port_bits) // see [RULE_08]
        else $error("port gate bits not written");

    property p_reserved_zero;
        @(posedge clock_i) disable iff (sys_rst_i)
        ((deep_gate_q & ~`DSG_GATE_MASK) == 32'h00000000)
            && ((prdata_o & ~`DSG_GATE_MASK) == 32'h00000000 || !$past(hit_deep));
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see [RULE_11]
        else $error("reserved gate bit is not zero");

    property p_ready_one_wait;
        @(posedge clock_i) disable iff (sys_rst_i)
        (psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o;
    endproperty
    a_ready_one_wait: assert property (p_ready_one_wait)
        else $error("apb ready not after exactly one wait cycle");

    // The interrupt flop is loaded from next status and mask, so it matches the unmasked status in the same cycle
    property p_irq_level;
        @(posedge clock_i) disable iff (sys_rst_i)
        irq_o == |(irq_stat_q & irq_mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line does not match unmasked status");

    property p_fault_sets_stat;
        @(posedge clock_i) disable iff (sys_rst_i)
        (unit_rsp_o.done && unit_rsp_o.fault) |=> irq_stat_q[`DSG_EV_FAULT];
    endproperty
    a_fault_sets_stat: assert property (p_fault_sets_stat) // see [RULE_02]
        else $error("access fault did not set its status bit");

    property p_err_with_ready;
        @(posedge clock_i) disable iff (sys_rst_i)
        pslverr_o |-> pready_o;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("apb error raised without ready");

    property p_other_reserved_zero;
        @(posedge clock_i) disable iff (sys_rst_i)
        ((run_gate_q | sleep_gate_q) & ~`DSG_GATE_MASK) == 32'h00000000;
    endproperty
    a_other_reserved_zero: assert property (p_other_reserved_zero) // see [RULE_11]
        else $error("reserved run or sleep gate bit is not zero");

    // Read data only stands in the cycle that ends a transfer
    property p_rdata_idle_zero;
        @(posedge clock_i) disable iff (sys_rst_i)
        !pready_o |-> (prdata_o == 32'h00000000);
    endproperty
    a_rdata_idle_zero: assert property (p_rdata_idle_zero)
        else $error("read data not zero outside a transfer end");

endmodule

// [testbench/dsg_unit_model.sv]
`timescale 1ns/100ps

// Stand-in for the gated units: turns a bench command into one access pulse
module dsg_unit_model
    import dsg_pkg::*;
(
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic write_i,
    input wire logic [3:0] unit_i,
    input wire dsg_gate_t clk_en_i,
    output dsg_req_s req_o,
    output logic clocked_o
);
    // Idle cycles scramble the unit field so a stale number is never trusted
    always_ff @(posedge clock_i) begin
        req_o.valid <= go_i;
        req_o.write <= write_i;
        req_o.unit <= go_i ? unit_i : ~req_o.unit;
    end

    // A unit only works while its enable is high
    assign clocked_o = (unit_i < 4'hA) && clk_en_i[unit_i];
endmodule

// [testbench/test_deep_sleep_clock_gating.sv]
`timescale 1ns/100ps
`include "dsg_regs.svh"

module test_deep_sleep_clock_gating;
    import dsg_pkg::*;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic sleep = 1'b0;
    logic deep = 1'b0;
    logic go = 1'b0;
    logic uwr = 1'b0;
    logic [3:0] unit = 4'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic irq_o;
    dsg_req_s req;
    dsg_rsp_s rsp;
    dsg_gate_t en_o;
    dsg_gate_t g;
    logic [32:0] exp_q[$];
    logic [31:0] rv[3];
    logic [31:0] d;
    int num_errors = 0;
    int checked = 0;
    int seed = 15603;

    always #20 clock_i = ~clock_i;

    dsg_top dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sleep_i(sleep), .deep_sleep_i(deep), .unit_req_i(req), .unit_rsp_o(rsp),
        .unit_clk_en_o(en_o), .irq_o(irq_o));

    dsg_unit_model model_u (.clock_i(clock_i), .go_i(go), .write_i(uwr), .unit_i(unit),
        .clk_en_i(en_o), .req_o(req), .clocked_o());

    task check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Own extraction of the unit enables from a gate word
    function automatic dsg_gate_t cmp(input logic [31:0] r);
        return {r[30], r[28], r[7:0]};
    endfunction

    // Request held until pready; release is left to idle so back-to-back works
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             input logic [32:0] exp);
        exp_q.push_back(exp);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1) @(posedge clock_i);
    endtask

    task idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask

    task end_of_test;
        // A result that never came back counts against the run
        if (exp_q.size() != 0) num_errors++;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Results are matched in arrival order against the driver's notes
    always @(posedge clock_i) begin
        if (pready_o === 1'b1 || rsp.done === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("mismatch at %0t: seen %h expected %h", $time, prdata_o, 0);
            end else if (pready_o === 1'b1)
                check({pslverr_o, prdata_o}, exp_q.pop_front());
            else
                check({32'h0, rsp.fault}, exp_q.pop_front());
        end
    end

    // Hang guard, far beyond the roughly 140 cycles the tests need
    initial begin
        repeat (20000) @(posedge clock_i);
        num_errors++;
        end_of_test;
    end

    initial begin
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        check({23'h0, en_o}, 33'h0);
        apb(1'b0, `DSG_DEEP_GATE_OFS, 32'h0, 33'h0);
        apb(1'b0, `DSG_RUN_GATE_OFS, 32'h0, 33'h0);
        apb(1'b0, `DSG_SLEEP_GATE_OFS, 32'h0, 33'h0);
        idle(1);
        $display("test reset values done");
        // Random words: only bits 30, 28 and 7..0 may stick
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            apb(1'b1, `DSG_DEEP_GATE_OFS, d, 33'h0);
            apb(1'b0, `DSG_DEEP_GATE_OFS, 32'h0, {1'b0, d & `DSG_GATE_MASK});
        end
        // Read-modify-write hands the reserved bits back as they were read
        d = (d & `DSG_GATE_MASK) ^ 32'h40000001;
        apb(1'b1, `DSG_DEEP_GATE_OFS, d, 33'h0);
        apb(1'b0, `DSG_DEEP_GATE_OFS, 32'h0, {1'b0, d});
        idle(1);
        $display("test field access done");
        for (int i = 0; i < 3; i++) rv[i] = $random(seed);
        apb(1'b1, `DSG_RUN_GATE_OFS, rv[0], 33'h0);
        apb(1'b1, `DSG_SLEEP_GATE_OFS, rv[1], 33'h0);
        apb(1'b1, `DSG_DEEP_GATE_OFS, rv[2], 33'h0);
        // Without auto gating the run word governs every state; with it each state takes its own word
        for (int a = 0; a < 2; a++) begin
            apb(1'b1, `DSG_RUN_CFG_OFS, {4'h0, a[0], 27'h0}, 33'h0);
            for (int s = 0; s < 3; s++) begin
                sleep <= (s == 1);
                deep <= (s == 2);
                idle(3);
                g = cmp(rv[a == 1 ? s : 0]);
                check({23'h0, en_o}, {23'h0, g});
            end
        end
        $display("test power state selection done");
        g = cmp(rv[2]);
        apb(1'b1, `DSG_IRQ_STAT_OFS, 32'h3, 33'h0);
        apb(1'b1, `DSG_IRQ_MASK_OFS, 32'h1, 33'h0);
        idle(1);
        // Back-to-back accesses to every unit number, valid or not
        for (int u = 0; u < 16; u++) begin
            go <= 1'b1;
            unit <= u[3:0];
            uwr <= u[0];
            exp_q.push_back({32'h0, (u > 9) ? 1'b1 : ~g[u]});
            @(posedge clock_i);
        end
        go <= 1'b0;
        idle(3);
        check({32'h0, irq_o}, 33'h1);
        apb(1'b0, `DSG_IRQ_STAT_OFS, 32'h0, 33'h1);
        apb(1'b1, `DSG_IRQ_STAT_OFS, 32'h1, 33'h0);
        idle(3);
        check({32'h0, irq_o}, 33'h0);
        $display("test access faults done");
        apb(1'b0, 12'h300, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h129, 32'hFFFFFFFF, {1'b1, 32'h0});
        apb(1'b0, `DSG_DEEP_GATE_OFS, 32'h0, {1'b0, rv[2] & `DSG_GATE_MASK});
        idle(1);
        $display("test unmapped access done");
        sys_rst_i <= 1'b1;
        idle(2);
        check({23'h0, en_o}, 33'h0);
        check({32'h0, irq_o}, 33'h0);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        apb(1'b0, `DSG_DEEP_GATE_OFS, 32'h0, 33'h0);
        apb(1'b0, `DSG_RUN_GATE_OFS, 32'h0, 33'h0);
        idle(2);
        $display("test reset in mid-run done");
        end_of_test;
    end
endmodule
